// ===== msctl_defs.svh
// Offsets, field positions, reset values and timing counts
`ifndef MSCTL_DEFS_SVH
`define MSCTL_DEFS_SVH
`define MSCTL_ADDR_MODE 7'h01
`define MSCTL_ADDR_HWC 7'h02
`define MSCTL_MODE_HI 7
`define MSCTL_MODE_LO 6
`define MSCTL_SEC_HI 4
`define MSCTL_SEC_LO 3
`define MSCTL_OVR_BIT 2
`define MSCTL_RT_HI 1
`define MSCTL_RT_LO 0
`define MSCTL_HWC_SRR_BIT 6
`define MSCTL_HWC_FO_BIT 5
`define MSCTL_HWC_CP_BIT 2
`define MSCTL_HWC_CFG_BIT 0
`define MSCTL_MODE_RST_VAL 8'h00
`define MSCTL_HWC_RST_VAL 8'h00
`define MSCTL_WD_LIMIT_FIRST 2'h1
`define MSCTL_WD_LIMIT_SECOND 2'h2
`define MSCTL_MODE_RW_MASK 8'hdf
`define MSCTL_HWC_RW_MASK 8'h65
`define MSCTL_MODE_RESTART_KEEP 8'h03
`define MSCTL_HWC_RESTART_KEEP 8'h45
`define MSCTL_SEC_DEV_VAL 2'h3
`define MSCTL_SPI_BITS 16
`endif

// ===== msctl_pkg.sv
// Types shared by the control register block
package msctl_pkg;
  typedef enum logic [1:0] {
    MSCTL_NORMAL = 2'h0,
    MSCTL_SLEEP = 2'h1,
    MSCTL_STOP = 2'h2,
    MSCTL_SOFTRST = 2'h3
  } msctl_mode_t;
  typedef enum logic [1:0] {
    MSCTL_SEC_OFF = 2'h0,
    MSCTL_SEC_NORMAL = 2'h1,
    MSCTL_SEC_NORM_STOP = 2'h2,
    MSCTL_SEC_ALWAYS = 2'h3
  } msctl_sec_t;
  typedef struct packed {
    logic soft_reset_keeps_reset_pin;
    logic software_fail_output_on;
    logic charge_pump_enable;
    logic watchdog_failure_count_select;
  } msctl_hwc_t;
  typedef struct packed {
    msctl_mode_t mode;
    msctl_sec_t secondary_regulator_mode;
    logic main_overvoltage_reaction;
    logic [1:0] main_reset_threshold;
  } msctl_ctl_t;
endpackage : msctl_pkg

// ===== msctl_spi_slave.sv
// SPI mode-0 shift engine: 16-bit frame, address byte then data byte
`timescale 1ns/1ns
`default_nettype none
`include "msctl_defs.svh"
module msctl_spi_slave
  import msctl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_output_pin,
  input wire logic spi_csn,
  input wire logic spi_clk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic addr_valid,
  output logic [6:0] addr,
  output logic wr_en,
  input wire logic [7:0] rd_data,
  output logic frame_done,
  output logic [7:0] wr_data
);
  logic [2:0] csn_s;
  logic [2:0] sck_s;
  logic [1:0] mosi_s;
  logic [15:0] shift;
  logic [4:0] cnt;
  logic [7:0] out_sr;
  logic rise;
  logic fall;
  logic cs_act;

  // Two flops before use; third stage only for edge detect
  always_ff @(posedge clk or negedge reset_output_pin) begin
    if (!reset_output_pin) begin
      csn_s <= 3'h7;
      sck_s <= 3'h0;
      mosi_s <= 2'h0;
    end else begin
      csn_s <= {csn_s[1:0], spi_csn};
      sck_s <= {sck_s[1:0], spi_clk};
      mosi_s <= {mosi_s[0], spi_mosi};
    end
  end
  assign cs_act = !csn_s[1];
  assign rise = sck_s[1] && !sck_s[2] && cs_act;
  assign fall = !sck_s[1] && sck_s[2] && cs_act;

  always_ff @(posedge clk or negedge reset_output_pin) begin
    if (!reset_output_pin) begin
      shift <= 16'h0000;
      cnt <= 5'h00;
    end else if (!cs_act) begin
      cnt <= 5'h00;
    end else if (rise) begin
      shift <= {shift[14:0], mosi_s[1]};
      cnt <= cnt + 5'h01;
    end
  end

  assign addr_valid = cs_act && (cnt == 5'h08);
  // Once the frame is complete the address sits in the upper byte
  assign addr = frame_done ? shift[14:8] : shift[6:0];

  // Old contents are latched at the address phase, so a write shows prior data
  always_ff @(posedge clk or negedge reset_output_pin) begin
    if (!reset_output_pin) begin
      out_sr <= 8'h00;
    end else if (addr_valid && rise == 1'b0 && fall) begin
      out_sr <= rd_data;
    end else if (fall && cnt > 5'h08) begin
      out_sr <= {out_sr[6:0], 1'b0};
    end
  end
  assign spi_miso = out_sr[7];
  assign spi_miso_oe = cs_act;

  always_ff @(posedge clk or negedge reset_output_pin) begin
    if (!reset_output_pin) begin
      frame_done <= 1'b0;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      frame_done <= 1'b0;
      if (csn_s[1] && !csn_s[2] && cnt == 5'(`MSCTL_SPI_BITS)) begin
        frame_done <= 1'b1;
        wr_en <= shift[15];
        wr_data <= shift[7:0];
      end
    end
  end
endmodule : msctl_spi_slave
`default_nettype wire

// ===== msctl_regs.sv
// Mode/supply and hardware control registers behind the SPI port
// Contract
// - Mode field 7:6: 00 normal, 01 sleep, 10 stop, 11 soft reset.
// - In stop, a sleep request is ignored; code holds stop but still writes bits 4:0 from the frame.
// - Stop to normal: bits 4:0 kept, fail flag set if written bits 4:0 differ, normal entered.
// - Restart entry rewrites the mode field to normal.
// - Restart entry or overtemperature forces secondary regulator off.
// - Secondary field 4:3 encodes off, normal, normal+stop, always.
// - Reserved bits read back zero.
// - Overvoltage reaction bit 2 adds restart/fail-safe on overvoltage.
// - Threshold field 1:0 selects one of four reset thresholds.
// - Reads during a write show the value before the write.
// - Development mode powers secondary regulator on; soft reset clears it.
// - Bit 6 chooses whether soft reset pulls the reset pin low.
// - Bit 5 lets software raise fail output if pin is fail output.
// - Bit 2 enables the charge pump.
// - Bit 0 chooses first or second watchdog failure for restart.
// - Clearing software bit never releases a failure-driven fail output.
// - Restart entry clears software fail bit.
// - Soft reset keeps locked reset-pin and charge-pump bits.
// - Reset clears mode register; restart keeps threshold bits only.
// - Restart keeps bits 6, 2, 0 of hardware register, clears rest.
`timescale 1ns/1ns
`default_nettype none
`include "msctl_defs.svh"
module msctl_regs
  import msctl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_output_pin,
  input wire logic spi_csn,
  input wire logic spi_clk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic development_mode,
  input wire logic in_stop_mode,
  input wire logic restart_entry,
  input wire logic overtemperature_event,
  input wire logic main_overvoltage_event,
  input wire logic lock_zero,
  input wire logic lock_one,
  input wire logic failure_fail_active,
  input wire logic gpio_is_fail_output,
  output msctl_ctl_t ctl,
  output msctl_hwc_t hwc,
  output logic mode_request,
  output logic soft_reset_pulse,
  output logic reset_output_pin_low,
  output logic spi_fail_set,
  output logic main_overvoltage_flag,
  output logic overvoltage_restart_req,
  output logic fail_output,
  output logic charge_pump_on,
  output logic [1:0] watchdog_fail_limit
);
  logic [6:0] addr;
  logic addr_valid;
  logic wr_en;
  logic frame_done;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] mode_reg;
  logic [7:0] hwc_reg;
  logic dev_seen;
  logic [1:0] dev_s;
  logic [1:0] dev_vld;
  logic wr_mode;
  logic wr_hwc;
  logic [1:0] req;
  logic stop_to_normal;

  msctl_spi_slave u_spi (
    .clk(clk),
    .reset_output_pin(reset_output_pin),
    .spi_csn(spi_csn),
    .spi_clk(spi_clk),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .addr_valid(addr_valid),
    .addr(addr),
    .wr_en(wr_en),
    .rd_data(rd_data),
    .frame_done(frame_done),
    .wr_data(wr_data)
  );

  function automatic logic [7:0] pack_hwc(input msctl_hwc_t h);
    pack_hwc = 8'h00;
    pack_hwc[`MSCTL_HWC_SRR_BIT] = h.soft_reset_keeps_reset_pin;
    pack_hwc[`MSCTL_HWC_FO_BIT] = h.software_fail_output_on;
    pack_hwc[`MSCTL_HWC_CP_BIT] = h.charge_pump_enable;
    pack_hwc[`MSCTL_HWC_CFG_BIT] = h.watchdog_failure_count_select;
  endfunction : pack_hwc

  // Strap sampled by two flops after reset release, never under reset
  always_ff @(posedge clk or negedge reset_output_pin) begin
    if (!reset_output_pin) begin
      dev_s <= 2'h0;
      dev_vld <= 2'h0;
    end else begin
      dev_s <= {dev_s[0], development_mode};
      dev_vld <= {dev_vld[0], 1'b1};
    end
  end

  // Write bit from the host selects the access
  assign wr_mode = frame_done && wr_en &&
                   (addr == `MSCTL_ADDR_MODE);
  assign wr_hwc = frame_done && wr_en &&
                  (addr == `MSCTL_ADDR_HWC);
  assign req = wr_data[`MSCTL_MODE_HI:`MSCTL_MODE_LO];
  assign stop_to_normal = wr_mode && in_stop_mode && req == 2'(MSCTL_NORMAL);

  // Mode and supply register
  always_ff @(posedge clk or negedge reset_output_pin) begin
    if (!reset_output_pin) begin
      mode_reg <= `MSCTL_MODE_RST_VAL;
      dev_seen <= 1'b0;
    end else if (restart_entry) begin
      mode_reg <= mode_reg & `MSCTL_MODE_RESTART_KEEP;
    end else begin
      // Strap only trusted once both sync stages hold it
      if (!dev_seen && dev_vld[1]) begin
        dev_seen <= 1'b1;
        if (dev_s[1]) begin
          mode_reg[`MSCTL_SEC_HI:`MSCTL_SEC_LO] <= `MSCTL_SEC_DEV_VAL;
        end
      end
      if (soft_reset_pulse) begin
        mode_reg <= `MSCTL_MODE_RST_VAL;
      end else if (stop_to_normal) begin
        mode_reg[`MSCTL_MODE_HI:`MSCTL_MODE_LO] <= 2'(MSCTL_NORMAL);
      end else if (wr_mode) begin
        mode_reg <= wr_data & `MSCTL_MODE_RW_MASK;
        if (in_stop_mode && req == 2'(MSCTL_SLEEP)) begin
          mode_reg[`MSCTL_MODE_HI:`MSCTL_MODE_LO] <= 2'(MSCTL_STOP);
        end
      end
      if (overtemperature_event) begin
        mode_reg[`MSCTL_SEC_HI:`MSCTL_SEC_LO] <= 2'(MSCTL_SEC_OFF);
      end
    end
  end

  // Soft reset executes one cycle after the 11 code lands
  always_ff @(posedge clk or negedge reset_output_pin) begin
    if (!reset_output_pin) begin
      soft_reset_pulse <= 1'b0;
      spi_fail_set <= 1'b0;
      mode_request <= 1'b0;
    end else begin
      soft_reset_pulse <= wr_mode && req == 2'(MSCTL_SOFTRST);
      spi_fail_set <= stop_to_normal &&
        ((wr_data[4:0] ^ mode_reg[4:0]) != 5'h00);
      mode_request <= wr_mode && !(in_stop_mode && req == 2'(MSCTL_SLEEP));
    end
  end

  // Hardware control register
  always_ff @(posedge clk or negedge reset_output_pin) begin
    if (!reset_output_pin) begin
      hwc_reg <= `MSCTL_HWC_RST_VAL;
    end else if (restart_entry) begin
      hwc_reg <= hwc_reg & `MSCTL_HWC_RESTART_KEEP;
    end else if (soft_reset_pulse) begin
      hwc_reg[`MSCTL_HWC_FO_BIT] <= 1'b0;
      hwc_reg[`MSCTL_HWC_CFG_BIT] <= 1'b0;
      if (!lock_one) begin
        hwc_reg[`MSCTL_HWC_SRR_BIT] <= 1'b0;
      end
      if (!lock_zero) begin
        hwc_reg[`MSCTL_HWC_CP_BIT] <= 1'b0;
      end
    end else if (wr_hwc) begin
      hwc_reg[`MSCTL_HWC_FO_BIT] <= wr_data[`MSCTL_HWC_FO_BIT];
      hwc_reg[`MSCTL_HWC_CFG_BIT] <= wr_data[`MSCTL_HWC_CFG_BIT];
      if (!lock_one) begin
        hwc_reg[`MSCTL_HWC_SRR_BIT] <= wr_data[`MSCTL_HWC_SRR_BIT];
      end
      if (!lock_zero) begin
        hwc_reg[`MSCTL_HWC_CP_BIT] <= wr_data[`MSCTL_HWC_CP_BIT];
      end
    end
  end

  // Read mux sampled at address phase, before any write lands
  always_comb begin
    case (addr)
      `MSCTL_ADDR_MODE: rd_data = mode_reg & `MSCTL_MODE_RW_MASK;
      `MSCTL_ADDR_HWC: rd_data = pack_hwc(hwc);
      default: rd_data = 8'h00;
    endcase
  end

  // One driver per struct; reserved bit 5 is skipped
  assign ctl = msctl_ctl_t'({mode_reg[`MSCTL_MODE_HI:`MSCTL_MODE_LO],
                             mode_reg[`MSCTL_SEC_HI:`MSCTL_RT_LO]});
  assign hwc = msctl_hwc_t'({hwc_reg[`MSCTL_HWC_SRR_BIT],
                             hwc_reg[`MSCTL_HWC_FO_BIT],
                             hwc_reg[`MSCTL_HWC_CP_BIT],
                             hwc_reg[`MSCTL_HWC_CFG_BIT]});

  // Derived controls registered so outputs come from flops
  always_ff @(posedge clk or negedge reset_output_pin) begin
    if (!reset_output_pin) begin
      reset_output_pin_low <= 1'b0;
      main_overvoltage_flag <= 1'b0;
      overvoltage_restart_req <= 1'b0;
      fail_output <= 1'b0;
      charge_pump_on <= 1'b0;
      watchdog_fail_limit <= `MSCTL_WD_LIMIT_SECOND;
    end else begin
      reset_output_pin_low <= soft_reset_pulse &&
        !hwc_reg[`MSCTL_HWC_SRR_BIT];
      // Flag is sticky; event wins over nothing here since no clear exists
      if (main_overvoltage_event) begin
        main_overvoltage_flag <= 1'b1;
      end
      overvoltage_restart_req <= main_overvoltage_event &&
        mode_reg[`MSCTL_OVR_BIT];
      fail_output <= failure_fail_active ||
        (hwc_reg[`MSCTL_HWC_FO_BIT] && gpio_is_fail_output);
      charge_pump_on <= hwc_reg[`MSCTL_HWC_CP_BIT];
      watchdog_fail_limit <= hwc_reg[`MSCTL_HWC_CFG_BIT] ?
        `MSCTL_WD_LIMIT_FIRST : `MSCTL_WD_LIMIT_SECOND;
    end
  end

  a_sleep_blocked: assert property (@(posedge clk) disable iff (!reset_output_pin)
    wr_mode && in_stop_mode && req == 2'(MSCTL_SLEEP) && !restart_entry
    && !soft_reset_pulse |=> mode_reg[7:6] == 2'(MSCTL_STOP))
    else $error("stop to sleep taken");
  a_stop_keep_low: assert property (@(posedge clk) disable iff (!reset_output_pin)
    stop_to_normal && !restart_entry && !soft_reset_pulse &&
    !overtemperature_event |=> mode_reg[4:0] == $past(mode_reg[4:0])
    && mode_reg[7:6] == 2'h0)
    else $error("stop to normal changed low bits");
  a_restart_mode: assert property (@(posedge clk) disable iff (!reset_output_pin)
    restart_entry |=> mode_reg[7:2] == 6'h00 &&
    mode_reg[1:0] == $past(mode_reg[1:0]))
    else $error("restart mode image wrong");
  a_ot_sec_off: assert property (@(posedge clk) disable iff (!reset_output_pin)
    overtemperature_event |=> mode_reg[4:3] == 2'h0)
    else $error("overtemperature left regulator on");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_output_pin)
    rd_data[5] == 1'b0 || addr != `MSCTL_ADDR_MODE)
    else $error("reserved bit read nonzero");
  a_lock_cp: assert property (@(posedge clk) disable iff (!reset_output_pin)
    lock_zero && !restart_entry |=> $stable(hwc_reg[2]))
    else $error("locked pump bit changed");
  a_fo_restart: assert property (@(posedge clk) disable iff (!reset_output_pin)
    restart_entry |=> hwc_reg[5] == 1'b0 ##1 fail_output ==
    $past(failure_fail_active))
    else $error("fail bit survived restart");
  a_srst_pin: assert property (@(posedge clk) disable iff (!reset_output_pin)
    soft_reset_pulse && !hwc_reg[6] |=> reset_output_pin_low)
    else $error("reset pin not driven on soft reset");

  // Multi-step behaviours spelled out as sequences
  sequence s_srst_write;
    wr_mode && req == 2'(MSCTL_SOFTRST) && !restart_entry;
  endsequence
  sequence s_srst_done;
    soft_reset_pulse ##1 (mode_reg[7:6] == 2'(MSCTL_NORMAL));
  endsequence
  sequence s_strap_apply;
    !dev_seen && dev_vld[1] && dev_s[1] && !restart_entry &&
    !soft_reset_pulse && !overtemperature_event && !wr_mode;
  endsequence

  a_srst_sequence: assert property (@(posedge clk) disable iff (!reset_output_pin)
    s_srst_write |=> s_srst_done)
    else $error("soft reset code did not execute");

  a_strap_on: assert property (@(posedge clk) disable iff (!reset_output_pin)
    s_strap_apply |=> mode_reg[4:3] == `MSCTL_SEC_DEV_VAL)
    else $error("development strap not applied");

  a_srst_clear: assert property (@(posedge clk) disable iff (!reset_output_pin)
    soft_reset_pulse && !restart_entry |=>
    mode_reg == `MSCTL_MODE_RST_VAL)
    else $error("soft reset left mode bits set");

  a_srst_lock_pin: assert property (@(posedge clk) disable iff (!reset_output_pin)
    soft_reset_pulse && lock_one && !restart_entry |=>
    $stable(hwc_reg[`MSCTL_HWC_SRR_BIT]))
    else $error("locked reset pin bit changed");

  a_srst_pump_off: assert property (@(posedge clk) disable iff (!reset_output_pin)
    soft_reset_pulse && !lock_zero && !restart_entry |=>
    !hwc_reg[`MSCTL_HWC_CP_BIT])
    else $error("unlocked pump bit survived soft reset");

  a_restart_hwc: assert property (@(posedge clk) disable iff (!reset_output_pin)
    restart_entry |=>
    hwc_reg == ($past(hwc_reg) & `MSCTL_HWC_RESTART_KEEP))
    else $error("restart image of hardware register wrong");

  a_restart_sec: assert property (@(posedge clk) disable iff (!reset_output_pin)
    restart_entry |=> mode_reg[4:3] == 2'(MSCTL_SEC_OFF))
    else $error("restart left regulator on");

  a_ov_flag_set: assert property (@(posedge clk) disable iff (!reset_output_pin)
    main_overvoltage_event |=> main_overvoltage_flag)
    else $error("overvoltage flag not set");

  a_ov_request: assert property (@(posedge clk) disable iff (!reset_output_pin)
    main_overvoltage_event |=>
    overvoltage_restart_req == $past(mode_reg[`MSCTL_OVR_BIT]))
    else $error("overvoltage reaction wrong");

  a_pump_follow: assert property (@(posedge clk) disable iff (!reset_output_pin)
    hwc_reg[`MSCTL_HWC_CP_BIT] |=> charge_pump_on)
    else $error("charge pump not enabled");

  a_wd_first: assert property (@(posedge clk) disable iff (!reset_output_pin)
    hwc_reg[`MSCTL_HWC_CFG_BIT] |=>
    watchdog_fail_limit == `MSCTL_WD_LIMIT_FIRST)
    else $error("watchdog failure count wrong");

  a_failure_holds: assert property (@(posedge clk) disable iff (!reset_output_pin)
    failure_fail_active |=> fail_output)
    else $error("failure did not hold fail output");

  a_stop_fail_flag: assert property (@(posedge clk) disable iff (!reset_output_pin)
    stop_to_normal && (wr_data[4:0] != mode_reg[4:0]) |=>
    spi_fail_set)
    else $error("spi fail flag not raised");

  a_sleep_no_req: assert property (@(posedge clk) disable iff (!reset_output_pin)
    wr_mode && in_stop_mode && req == 2'(MSCTL_SLEEP) |=>
    !mode_request)
    else $error("sleep request passed in stop");

  a_hwc_reserved: assert property (@(posedge clk) disable iff (!reset_output_pin)
    addr == `MSCTL_ADDR_HWC |->
    (rd_data & ~`MSCTL_HWC_RW_MASK) == 8'h00)
    else $error("reserved hardware bit read nonzero");
endmodule : msctl_regs
`default_nettype wire

// ===== msctl_host.sv
// Host model: SPI master sending 16-bit frames
`timescale 1ns/1ns
`default_nettype none
module msctl_host (
  input wire logic clk,
  output logic spi_csn,
  output logic spi_clk,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_csn = 1'b1;
    spi_clk = 1'b0;
    spi_mosi = 1'b0;
  end
  // Write flag, address, data, MSB first; byte shifted back is returned
  task automatic xfer(input logic wr, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    w = {wr, a, d};
    q = 8'h00;
    @(posedge clk);
    spi_csn <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (8) @(posedge clk);
      spi_clk <= 1'b0;
      spi_mosi <= w[i];
      repeat (8) @(posedge clk);
      if (i < 8) q[i] = spi_miso;
      spi_clk <= 1'b1;
    end
    repeat (8) @(posedge clk);
    spi_clk <= 1'b0;
    repeat (8) @(posedge clk);
    spi_csn <= 1'b1;
    // Released line must not look like a held bit
    spi_mosi <= ~w[0];
    repeat (16) @(posedge clk);
  endtask : xfer
endmodule : msctl_host
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the mode and hardware control registers
`timescale 1ns/1ns
`default_nettype none
`include "msctl_defs.svh"
module tb_top;
  import msctl_pkg::*;
  localparam logic [6:0] ma = `MSCTL_ADDR_MODE;
  localparam logic [6:0] ha = `MSCTL_ADDR_HWC;
  logic clk = 1'b0, reset_output_pin = 1'b0, dev = 1'b1, stop = 1'b0, rs = 1'b0;
  logic ot = 1'b0, ov = 1'b0, lk0 = 1'b0, lk1 = 1'b0, fl = 1'b0;
  logic gfo = 1'b0;
  logic csn, sck, mosi, miso, miso_oe;
  logic mreq, srst, rpl, sfail, ovf, ovreq, fo, cp;
  logic [1:0] wdl;
  msctl_ctl_t ctl;
  msctl_hwc_t hwc;
  int fail_count = 0, checks_done = 0;
  int n_srst = 0, n_rpl = 0, n_sf = 0, n_ovr = 0, n_mr = 0;
  always #2 clk = ~clk;
  msctl_host i_host (.clk(clk), .spi_csn(csn), .spi_clk(sck),
    .spi_mosi(mosi), .spi_miso(miso));
  msctl_regs i_dut (
    .clk(clk), .reset_output_pin(reset_output_pin), .spi_csn(csn), .spi_clk(sck),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
    .development_mode(dev), .in_stop_mode(stop),
    .restart_entry(rs), .overtemperature_event(ot),
    .main_overvoltage_event(ov), .lock_zero(lk0), .lock_one(lk1),
    .failure_fail_active(fl), .gpio_is_fail_output(gfo),
    .ctl(ctl), .hwc(hwc), .mode_request(mreq),
    .soft_reset_pulse(srst), .reset_output_pin_low(rpl),
    .spi_fail_set(sfail), .main_overvoltage_flag(ovf),
    .overvoltage_restart_req(ovreq), .fail_output(fo),
    .charge_pump_on(cp), .watchdog_fail_limit(wdl));
  // Pulses are one cycle wide, so count them as they pass
  always @(posedge clk) begin
    if (srst === 1'b1) n_srst++;
    if (rpl === 1'b1) n_rpl++;
    if (sfail === 1'b1) n_sf++;
    if (ovreq === 1'b1) n_ovr++;
    if (mreq === 1'b1) n_mr++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    i_host.xfer(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rd
  // Write returns the value held before this write
  task automatic wr(input logic [6:0] a, input logic [7:0] d,
                    input logic [7:0] old);
    logic [7:0] q;
    i_host.xfer(1'b1, a, d, q);
    chk(q, old);
  endtask : wr
  task automatic strobe(input int sel);
    @(posedge clk);
    rs <= (sel == 0);
    ot <= (sel == 1);
    ov <= (sel == 2);
    @(posedge clk);
    rs <= 1'b0;
    ot <= 1'b0;
    ov <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : strobe
  task automatic t_power();
    chk({7'h0, miso_oe}, 8'h00);
    chk({7'h0, ovf}, 8'h00);
    rd(ma, 8'h18);
    rd(ha, 8'h00);
    chk({6'h0, wdl}, 8'h02);
    wr(7'h05, 8'haa, 8'h00);
    rd(7'h05, 8'h00);
  endtask : t_power
  task automatic t_soft();
    wr(ma, 8'hc0, 8'h18);
    chk(8'(n_srst), 8'h01);
    chk(8'(n_rpl), 8'h01);
    rd(ma, 8'h00);
    wr(ha, 8'h45, 8'h00);
    chk({7'h0, cp}, 8'h01);
    chk({6'h0, wdl}, 8'h01);
    chk({4'h0, hwc}, 8'h0b);
    lk0 <= 1'b1;
    lk1 <= 1'b1;
    wr(ma, 8'hc0, 8'h00);
    chk(8'(n_srst), 8'h02);
    chk(8'(n_rpl), 8'h01);
    rd(ha, 8'h44);
    wr(ha, 8'h01, 8'h44);
    rd(ha, 8'h45);
    lk0 <= 1'b0;
    lk1 <= 1'b0;
    wr(ha, 8'h00, 8'h45);
    chk({7'h0, cp}, 8'h00);
    chk({6'h0, wdl}, 8'h02);
  endtask : t_soft
  task automatic t_fields();
    int m0;
    logic [7:0] v;
    logic [7:0] prev;
    m0 = n_mr;
    prev = 8'h00;
    for (int i = 0; i < 4; i++) begin
      v = {(i == 3) ? 2'b00 : i[1:0], 1'b0, i[1:0], 1'b0, i[1:0]};
      wr(ma, v, prev);
      prev = v;
      chk({6'h0, ctl.mode}, {6'h0, v[7:6]});
      chk({6'h0, ctl.secondary_regulator_mode}, {6'h0, i[1:0]});
      chk({6'h0, ctl.main_reset_threshold}, {6'h0, i[1:0]});
    end
    chk(8'(n_mr - m0), 8'h04);
  endtask : t_fields
  task automatic t_reserved();
    wr(ma, 8'h9f, 8'h1b);
    rd(ma, 8'h9f);
    wr(ha, 8'h65, 8'h00);
    rd(ha, 8'h65);
  endtask : t_reserved
  task automatic t_fail();
    chk({7'h0, fo}, 8'h00);
    gfo <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h0, fo}, 8'h01);
    fl <= 1'b1;
    wr(ha, 8'h45, 8'h65);
    chk({7'h0, fo}, 8'h01);
    fl <= 1'b0;
    repeat (4) @(posedge clk);
    chk({7'h0, fo}, 8'h00);
    wr(ha, 8'h65, 8'h45);
    chk({7'h0, fo}, 8'h01);
    strobe(0);
    chk({7'h0, fo}, 8'h00);
    rd(ha, 8'h45);
    rd(ma, 8'h03);
  endtask : t_fail
  task automatic t_over();
    wr(ma, 8'h1b, 8'h03);
    strobe(1);
    rd(ma, 8'h03);
    strobe(2);
    chk({7'h0, ovf}, 8'h01);
    chk(8'(n_ovr), 8'h00);
    wr(ma, 8'h07, 8'h03);
    chk({7'h0, ctl.main_overvoltage_reaction}, 8'h01);
    strobe(2);
    chk(8'(n_ovr), 8'h01);
  endtask : t_over
  task automatic t_stop();
    int m0;
    wr(ma, 8'h83, 8'h07);
    stop <= 1'b1;
    m0 = n_mr;
    wr(ma, 8'h43, 8'h83);
    chk(8'(n_mr - m0), 8'h00);
    rd(ma, 8'h83);
    wr(ma, 8'h1b, 8'h83);
    rd(ma, 8'h03);
    chk(8'(n_sf), 8'h01);
    stop <= 1'b0;
  endtask : t_stop
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_output_pin <= 1'b1;
    repeat (4) @(posedge clk);
    t_power();
    t_soft();
    t_fields();
    t_reserved();
    t_fail();
    t_over();
    t_stop();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
